// ==== src/mss_pkg.sv ====
// Contract
// - on command energises function's contactors
// - latch on command until off, unless inching
// - current present lights run lamp and status
// - off command drops all energised contactors
// - no current lights stopped lamp and status
// - fault drops contactors, flashes lamp, flags
// - no current within run time: fault
// - current after run time off: fault, block
// - run time zero disables run supervision
// - unexpected current when off: fault, block
// - missing current when on: fault, drop
// - reversing never energises both directions
// - direction change needs off, no current, lockout
// - lockout zero skips the delay
// - star delta starts star, then delta
// - current changeover at 0.9 set current
// - time changeover after twice class time
// - star dropout confirmed before delta
package mss_pkg;

   // starter function selection
   typedef enum logic [1:0] {
      MSS_FN_DIRECT = 2'h0,
      MSS_FN_REVERSE = 2'h1,
      MSS_FN_STAR_DELTA = 2'h2
   } mss_func_t;

   // motor sequence, gray coded along the start path
   typedef enum logic [2:0] {
      MSS_ST_OFF = 3'h0,
      MSS_ST_RUN = 3'h1,
      MSS_ST_STAR = 3'h4,
      MSS_ST_GAP = 3'h5,
      MSS_ST_DELTA = 3'h7
   } mss_state_t;

   // the three contactor drives
   typedef struct packed {
      logic c;
      logic b;
      logic a;
   } mss_cont_t;

   // sticky fault bits
   typedef struct packed {
      logic checkback_on;
      logic missing_current;
      logic run_off;
      logic run_on;
   } mss_fault_t;

   localparam int unsigned MSS_TIME_W = 16;
   localparam logic [MSS_TIME_W-1:0] MSS_TIME_ZERO = 16'h0000;
   // changeover threshold 0.9 as 9/10
   localparam int unsigned MSS_CHG_NUM = 9;
   localparam int unsigned MSS_CHG_DEN = 10;
   // time changeover factor on class time
   localparam int unsigned MSS_CLASS_MUL = 2;
   // flash half period in ticks
   localparam int unsigned MSS_FLASH_TICKS = 2;

endpackage

// ==== src/mss_timer.sv ====
`timescale 1ns/10ps
module mss_timer #(
   parameter int unsigned W = 16
) (
   input wire logic core_clk_i, // clock
   input wire logic rst_i, // sync reset
   input wire logic run_i, // count while high, clear when low
   input wire logic tick_i, // time base tick
   input wire logic [W-1:0] limit_i, // limit in ticks
   output logic expired_o // count passed limit
);
   logic [W:0] count;

   // saturating tick counter
   always_ff @(posedge core_clk_i) begin
      if (rst_i || !run_i) begin
         count <= '0;
      end else if (tick_i && !count[W]) begin
         count <= count + 1'b1;
      end
   end

   assign expired_o = run_i && (count > {1'b0, limit_i});
endmodule

// ==== src/mss_sequencer.sv ====
`timescale 1ns/10ps
module mss_sequencer #(
   parameter int unsigned TW = 16, // timer width
   parameter int unsigned IW = 16 // current value width
) (
   input wire logic core_clk_i, // 250 MHz clock
   input wire logic rst_i, // sync reset
   input wire logic tick_i, // time base tick
   input wire mss_pkg::mss_func_t func_i, // starter function
   input wire logic inching_i, // inching mode
   input wire logic changeover_by_current_i, // star delta by current
   input wire logic on_station_first_i, // on1 command
   input wire logic on_station_second_i, // on2 command
   input wire logic off_station_i, // off command
   input wire logic current_present_i, // main circuit current
   input wire logic [IW-1:0] motor_current_i, // measured current
   input wire logic [IW-1:0] set_current_i, // set current
   input wire logic [TW-1:0] run_time_i, // run time limit
   input wire logic [TW-1:0] checkback_on_time_i, // on check-back
   input wire logic [TW-1:0] checkback_off_time_i, // off check-back
   input wire logic [TW-1:0] lockout_time_i, // lock-out time
   input wire logic [TW-1:0] class_time_i, // trip class time
   input wire logic fault_clear_i, // clear faults
   output mss_pkg::mss_cont_t contactor_o, // contactor drives
   output logic lamp_run_first_o, // on1 lamp
   output logic lamp_run_second_o, // on2 lamp
   output logic lamp_stopped_o, // off lamp
   output logic lamp_fault_o, // flashing fault lamp
   output logic gen_fault_flash_o, // general fault flash
   output logic status_on_first_o, // on1 status
   output logic status_on_second_o, // on2 status
   output logic status_off_o, // off status
   output logic status_fault_o, // general fault status
   output mss_pkg::mss_fault_t fault_o // specific fault bits
);
   ////////////////////////////////////////////////////////////////////
   mss_pkg::mss_state_t state;
   mss_pkg::mss_state_t next_state;
   mss_pkg::mss_fault_t fault;
   logic dir_second; // second station selected
   logic cmd_on; // motor commanded on
   logic off_pending; // off command run time watch
   logic any_fault;
   logic lockout_run;
   logic lock_exp, run_on_exp, run_off_exp, cbon_exp, cboff_exp;
   logic class_exp;
   logic on_req, dir_req, dir_ok, cur_low;
   logic [TW:0] class_limit;
   logic [IW+3:0] cur_scaled, set_scaled;
   logic [3:0] flash_cnt;
   logic flash;
   mss_pkg::mss_cont_t next_cont;

   assign any_fault = |fault;
   assign on_req = on_station_first_i || on_station_second_i;
   // reversing requests direction of the pressed station
   assign dir_req = on_station_second_i;

   ////////////////////////////////////////////////////////////////////
   // timers
   assign lockout_run = (state == mss_pkg::MSS_ST_OFF)
                        && !current_present_i;
   mss_timer #(.W(TW)) u_lock (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .run_i(lockout_run),
      .tick_i(tick_i), .limit_i(lockout_time_i), .expired_o(lock_exp)
   );
   mss_timer #(.W(TW)) u_run_on (
      .core_clk_i(core_clk_i), .rst_i(rst_i),
      .run_i(cmd_on && !current_present_i && !off_pending),
      .tick_i(tick_i), .limit_i(run_time_i), .expired_o(run_on_exp)
   );
   mss_timer #(.W(TW)) u_run_off (
      .core_clk_i(core_clk_i), .rst_i(rst_i),
      .run_i(off_pending && current_present_i),
      .tick_i(tick_i), .limit_i(run_time_i), .expired_o(run_off_exp)
   );
   mss_timer #(.W(TW)) u_cb_on (
      .core_clk_i(core_clk_i), .rst_i(rst_i),
      .run_i(!cmd_on && !off_pending && current_present_i),
      .tick_i(tick_i), .limit_i(checkback_on_time_i),
      .expired_o(cbon_exp)
   );
   mss_timer #(.W(TW)) u_cb_off (
      .core_clk_i(core_clk_i), .rst_i(rst_i),
      .run_i(cmd_on && !current_present_i
             && (state != mss_pkg::MSS_ST_GAP)),
      .tick_i(tick_i), .limit_i(checkback_off_time_i),
      .expired_o(cboff_exp)
   );
   // class time doubled for changeover
   assign class_limit = (TW+1)'(mss_pkg::MSS_CLASS_MUL) * {1'b0, class_time_i};
   mss_timer #(.W(TW+1)) u_class (
      .core_clk_i(core_clk_i), .rst_i(rst_i),
      .run_i(state == mss_pkg::MSS_ST_STAR),
      .tick_i(tick_i), .limit_i(class_limit), .expired_o(class_exp)
   );

   // current at or below 0.9 set current
   assign cur_scaled = (IW+4)'(motor_current_i)
                       * (IW+4)'(mss_pkg::MSS_CHG_DEN);
   assign set_scaled = (IW+4)'(set_current_i) * (IW+4)'(mss_pkg::MSS_CHG_NUM);
   assign cur_low = cur_scaled <= set_scaled;

   // direction change allowed only from rest after lockout
   assign dir_ok = (func_i != mss_pkg::MSS_FN_REVERSE)
                   || (dir_req == dir_second)
                   || (lockout_run && (lock_exp
                       || (lockout_time_i == mss_pkg::MSS_TIME_ZERO)));

   ////////////////////////////////////////////////////////////////////
   // sticky faults, set wins over clear
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         fault <= '0;
      end else begin
         if (fault_clear_i) begin
            fault <= '0;
         end
         // run supervision off when limit is zero
         if (run_time_i != mss_pkg::MSS_TIME_ZERO) begin
            if (run_on_exp) begin
               fault.run_on <= 1'b1;
            end
            if (run_off_exp) begin
               fault.run_off <= 1'b1;
            end
         end
         if (cbon_exp) begin
            fault.checkback_on <= 1'b1;
         end
         if (cboff_exp) begin
            fault.missing_current <= 1'b1;
         end
      end
   end

   // on latch: stored until off, or level in inching
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cmd_on <= 1'b0;
         dir_second <= 1'b0;
      end else if (off_station_i || any_fault) begin
         cmd_on <= 1'b0;
      end else if (inching_i) begin
         cmd_on <= on_req && (cmd_on || dir_ok);
         if (!cmd_on && on_req && dir_ok) begin
            dir_second <= dir_req;
         end
      end else if (on_req && !cmd_on && dir_ok) begin
         cmd_on <= 1'b1;
         dir_second <= dir_req;
      end
   end

   // off watch for run time off
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         off_pending <= 1'b0;
      end else if (cmd_on && (off_station_i || inching_i && !on_req)) begin
         off_pending <= 1'b1;
      end else if (!current_present_i || cmd_on) begin
         off_pending <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // motor sequence
   always_comb begin
      next_state = state;
      case (state)
         mss_pkg::MSS_ST_OFF: begin
            if (cmd_on) begin
               next_state = (func_i == mss_pkg::MSS_FN_STAR_DELTA)
                            ? mss_pkg::MSS_ST_STAR : mss_pkg::MSS_ST_RUN;
            end
         end
         mss_pkg::MSS_ST_RUN: begin
            if (!cmd_on) begin
               next_state = mss_pkg::MSS_ST_OFF;
            end
         end
         mss_pkg::MSS_ST_STAR: begin
            if (!cmd_on) begin
               next_state = mss_pkg::MSS_ST_OFF;
            end else if (changeover_by_current_i ? (current_present_i
                         && cur_low) : class_exp) begin
               next_state = mss_pkg::MSS_ST_GAP;
            end
         end
         mss_pkg::MSS_ST_GAP: begin
            if (!cmd_on) begin
               next_state = mss_pkg::MSS_ST_OFF;
            end else if (!current_present_i) begin
               next_state = mss_pkg::MSS_ST_DELTA;
            end
         end
         mss_pkg::MSS_ST_DELTA: begin
            if (!cmd_on) begin
               next_state = mss_pkg::MSS_ST_OFF;
            end
         end
         default: next_state = mss_pkg::MSS_ST_OFF;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state <= mss_pkg::MSS_ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // contactor decode per function
   always_comb begin
      next_cont = '0;
      if (cmd_on && !any_fault) begin
         case (func_i)
            mss_pkg::MSS_FN_REVERSE: begin
               // exactly one direction
               next_cont.a = !dir_second;
               next_cont.b = dir_second;
            end
            mss_pkg::MSS_FN_STAR_DELTA: begin
               // mains held, star then delta
               next_cont.a = 1'b1;
               next_cont.b = (next_state == mss_pkg::MSS_ST_STAR);
               next_cont.c = (next_state == mss_pkg::MSS_ST_DELTA);
            end
            default: next_cont.a = 1'b1;
         endcase
      end
   end

   // registered contactor drives, cleared on fault
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         contactor_o <= '0;
      end else begin
         contactor_o <= next_cont;
      end
   end

   // flash divider on ticks
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         flash_cnt <= '0;
         flash <= 1'b0;
      end else if (tick_i) begin
         if (flash_cnt == 4'(mss_pkg::MSS_FLASH_TICKS - 1)) begin
            flash_cnt <= '0;
            flash <= !flash;
         end else begin
            flash_cnt <= flash_cnt + 1'b1;
         end
      end
   end

   // lamps and status from current check-back, fault lamp and status from fault bits
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lamp_run_first_o <= 1'b0;
         lamp_run_second_o <= 1'b0;
         lamp_stopped_o <= 1'b0;
         lamp_fault_o <= 1'b0;
         gen_fault_flash_o <= 1'b0;
         status_on_first_o <= 1'b0;
         status_on_second_o <= 1'b0;
         status_off_o <= 1'b0;
         status_fault_o <= 1'b0;
         fault_o <= '0;
      end else begin
         lamp_run_first_o <= current_present_i && !dir_second
                             && (func_i == mss_pkg::MSS_FN_REVERSE);
         lamp_run_second_o <= current_present_i && (dir_second
                             || func_i != mss_pkg::MSS_FN_REVERSE);
         status_on_first_o <= current_present_i && !dir_second
                              && (func_i == mss_pkg::MSS_FN_REVERSE);
         status_on_second_o <= current_present_i && (dir_second
                              || func_i != mss_pkg::MSS_FN_REVERSE);
         lamp_stopped_o <= !current_present_i;
         status_off_o <= !current_present_i;
         lamp_fault_o <= any_fault && flash;
         gen_fault_flash_o <= any_fault && flash;
         status_fault_o <= any_fault;
         fault_o <= fault;
      end
   end

   ////////////////////////////////////////////////////////////////////
   sequence s_fault_raised;
      $rose(any_fault);
   endsequence

   property p_fault_drop;
      @(posedge core_clk_i) disable iff (rst_i)
         s_fault_raised |=> (contactor_o == '0);
   endproperty
   a_fault_drop: assert property (p_fault_drop)
      else $error("contactors not dropped on fault");

   property p_rev_excl;
      @(posedge core_clk_i) disable iff (rst_i)
         !(contactor_o.a && contactor_o.b
           && func_i == mss_pkg::MSS_FN_REVERSE);
   endproperty
   a_rev_excl: assert property (p_rev_excl)
      else $error("both directions energised");

   property p_off_drop;
      @(posedge core_clk_i) disable iff (rst_i)
         off_station_i ##1 1'b1 |=> (contactor_o == '0);
   endproperty
   a_off_drop: assert property (p_off_drop)
      else $error("off command left a contactor on");

   property p_star_delta;
      @(posedge core_clk_i) disable iff (rst_i)
         $rose(contactor_o.c) |-> contactor_o.a && !contactor_o.b
            && $past(!contactor_o.b) && !$past(current_present_i);
   endproperty
   a_star_delta: assert property (p_star_delta)
      else $error("delta raised before star dropout");

   property p_stopped_lamp;
      @(posedge core_clk_i) disable iff (rst_i)
         !current_present_i |=> lamp_stopped_o && status_off_o;
   endproperty
   a_stopped_lamp: assert property (p_stopped_lamp)
      else $error("stopped lamp missing");

   property p_run_lamp;
      @(posedge core_clk_i) disable iff (rst_i)
         current_present_i |=> (lamp_run_first_o || lamp_run_second_o)
            && !lamp_stopped_o;
   endproperty
   a_run_lamp: assert property (p_run_lamp)
      else $error("run lamp missing");

   property p_runtime_zero;
      @(posedge core_clk_i) disable iff (rst_i)
         (run_time_i == mss_pkg::MSS_TIME_ZERO) && !fault.run_on
         && !fault.run_off |=> !fault.run_on && !fault.run_off;
   endproperty
   a_runtime_zero: assert property (p_runtime_zero)
      else $error("run fault with supervision off");

   property p_block;
      @(posedge core_clk_i) disable iff (rst_i)
         fault.checkback_on || fault.run_off |=> contactor_o == '0;
   endproperty
   a_block: assert property (p_block)
      else $error("re-energised while blocked");
endmodule

// ==== bench/mss_plant.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// behavioural main circuit: contactors, motor and current sensing
module mss_plant (
   input wire logic core_clk_i, // clock
   input wire mss_pkg::mss_func_t func_i, // starter function
   input wire mss_pkg::mss_cont_t contactor_i, // contactor drives
   input wire logic slow_i, // slow contactor action
   input wire logic fail_i, // main circuit broken
   input wire logic weld_i, // welded contacts
   output logic current_present_o, // main circuit current
   output logic [15:0] motor_current_o // measured current
);
   logic [7:0] pipe = 8'h00;
   logic path;
   logic star_d = 1'b0;
   logic [15:0] level = 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // star delta needs mains plus star or delta to close the circuit
   assign path = (func_i == mss_pkg::MSS_FN_STAR_DELTA) ?
      (contactor_i.a & (contactor_i.b | contactor_i.c)) :
      (contactor_i.a | contactor_i.b);

   // contactor pick-up and drop-out delay, short or long
   always @(posedge core_clk_i) begin
      pipe <= {pipe[6:0], path};
   end

   // current follows the delayed circuit path, forced on by weld, cut by fail
   assign current_present_o = weld_i |
      (~fail_i & (slow_i ? pipe[7] : pipe[1]));

   ////////////////////////////////////////////////////////////////////////
   // start current falls steadily through the star stage
   always @(posedge core_clk_i) begin
      star_d <= contactor_i.b;
      if (contactor_i.b && !star_d)
         level <= 16'h00C8;
      else if (contactor_i.b && level != 16'h0000)
         level <= level - 16'h0001;
   end
   assign motor_current_o = level;
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// self-checking bench for the starter sequencer
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   mss_pkg::mss_func_t func = mss_pkg::MSS_FN_DIRECT;
   logic inch = 1'b0, by_cur = 1'b0, on1 = 1'b0, on2 = 1'b0, off = 1'b0;
   logic clr = 1'b0, slow = 1'b0, fail = 1'b0, weld = 1'b0;
   logic cur, prev_cur = 1'b0, prev_c = 1'b0;
   logic [15:0] mcur;
   logic [15:0] rt = 16'h0028, cbon = 16'h0014, cboff = 16'h0014;
   logic [15:0] lock = 16'h001E, cls = 16'h0032;
   mss_pkg::mss_cont_t cont;
   mss_pkg::mss_fault_t flt;
   logic l1, l2, ls, lf, gff, s1, s2, so, sf;
   int fails = 0, comparisons = 0, cycles = 0, n, k;

   // 250 MHz clock
   initial begin
      forever #2 clk = ~clk;
   end

   mss_sequencer mss_sequencer_i (.core_clk_i(clk), .rst_i(rst),
      .tick_i(1'b1), .func_i(func), .inching_i(inch),
      .changeover_by_current_i(by_cur), .on_station_first_i(on1),
      .on_station_second_i(on2), .off_station_i(off),
      .current_present_i(cur), .motor_current_i(mcur),
      .set_current_i(16'h0064), .run_time_i(rt),
      .checkback_on_time_i(cbon), .checkback_off_time_i(cboff),
      .lockout_time_i(lock), .class_time_i(cls), .fault_clear_i(clr),
      .contactor_o(cont), .lamp_run_first_o(l1), .lamp_run_second_o(l2),
      .lamp_stopped_o(ls), .lamp_fault_o(lf), .gen_fault_flash_o(gff),
      .status_on_first_o(s1), .status_on_second_o(s2),
      .status_off_o(so), .status_fault_o(sf), .fault_o(flt));

   mss_plant mss_plant_i (.core_clk_i(clk), .func_i(func),
      .contactor_i(cont), .slow_i(slow), .fail_i(fail), .weld_i(weld),
      .current_present_o(cur), .motor_current_o(mcur));

   ////////////////////////////////////////////////////////////////////////
   // closing report
   task automatic summarize();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // compare one flag
   task automatic chk_bit(input logic got, input logic exp, input string m);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   // step c cycles, inputs change 1 ns after the edge
   task automatic cyc(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   // one-cycle command pulse
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask

   // contactor pattern reached within a bound
   task automatic chk_cont(input mss_pkg::mss_cont_t exp, input int max);
      n = 0;
      while (cont !== exp && n < max) begin
         cyc(1);
         n++;
      end
      chk_bit(cont === exp, 1'b1, "contactor pattern");
   endtask

   // fault bit raised within a bound
   task automatic chk_flt(input int b, input int max);
      n = 0;
      while (flt[b] !== 1'b1 && n < max) begin
         cyc(1);
         n++;
      end
      chk_bit(flt[b], 1'b1, "fault bit");
   endtask

   // stop, settle and clear faults
   task automatic clear_all();
      pulse(off);
      weld = 1'b0;
      fail = 1'b0;
      cyc(12);
      pulse(clr);
      cyc(2);
      chk_bit(flt === 4'h0, 1'b1, "faults cleared");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // cycle watch: timeout and contactor interlocks
   always @(posedge clk) begin
      cycles++;
      prev_cur <= cur;
      prev_c <= cont.c;
      if (cycles == 8000) begin
         fails++;
         summarize();
      end
      if (!rst && func == mss_pkg::MSS_FN_REVERSE)
         chk_bit(cont.a & cont.b, 1'b0, "both directions");
      if (!rst && func == mss_pkg::MSS_FN_STAR_DELTA && cont.c)
         chk_bit(cont.a & !cont.b, 1'b1, "delta stage");
      if (!rst && cont.c && !prev_c)
         chk_bit(prev_cur, 1'b0, "delta with current");
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      cyc(10);
      rst = 1'b0;
      cyc(2);
      chk_bit(cont === 3'h0 && flt === 4'h0, 1'b1, "reset state");
      chk_bit(ls & so, 1'b1, "stopped lamp");
      // direct start with slow pick-up, pulse latched
      slow = 1'b1;
      pulse(on2);
      chk_cont(3'h1, 3);
      cyc(12);
      chk_bit(cont === 3'h1, 1'b1, "latched");
      chk_bit(l2 & s2 & !ls & !so, 1'b1, "run lamp");
      slow = 1'b0;
      pulse(off);
      chk_cont(3'h0, 3);
      cyc(12);
      chk_bit(ls & so & !l2 & !s2, 1'b1, "stopped");
      // inching drops with the command
      inch = 1'b1;
      on2 = 1'b1;
      cyc(6);
      chk_bit(cont === 3'h1, 1'b1, "inching on");
      on2 = 1'b0;
      chk_cont(3'h0, 4);
      inch = 1'b0;
      cyc(8);
      // no current after on: run time fault
      cboff = 16'h00C8;
      fail = 1'b1;
      pulse(on2);
      chk_flt(0, 50);
      chk_cont(3'h0, 3);
      k = 0;
      n = 0;
      repeat (10) begin
         cyc(1);
         k += lf;
         n += gff;
      end
      chk_bit(k > 0 && k < 10, 1'b1, "fault lamp flash");
      chk_bit(n > 0 && sf === 1'b1, 1'b1, "general fault");
      clear_all();
      // run time zero disables supervision
      rt = 16'h0000;
      fail = 1'b1;
      pulse(on2);
      cyc(60);
      chk_bit(flt.run_on, 1'b0, "run supervision off");
      chk_bit(cont === 3'h1, 1'b1, "still on");
      clear_all();
      rt = 16'h0028;
      cboff = 16'h0014;
      // current lost while running
      pulse(on2);
      chk_cont(3'h1, 3);
      cyc(10);
      fail = 1'b1;
      chk_flt(2, 35);
      chk_cont(3'h0, 3);
      clear_all();
      // current while stopped, restart blocked
      weld = 1'b1;
      chk_flt(3, 35);
      pulse(on2);
      cyc(4);
      chk_bit(cont === 3'h0, 1'b1, "blocked");
      clear_all();
      // current persists after off
      pulse(on2);
      chk_cont(3'h1, 3);
      cyc(6);
      weld = 1'b1;
      pulse(off);
      chk_cont(3'h0, 3);
      chk_flt(1, 55);
      pulse(on2);
      cyc(4);
      chk_bit(cont === 3'h0, 1'b1, "blocked");
      clear_all();
      // reversing: interlock and lock-out
      func = mss_pkg::MSS_FN_REVERSE;
      cyc(40);
      pulse(on1);
      chk_cont(3'h1, 3);
      cyc(4);
      chk_bit(l1 & s1, 1'b1, "left lamp");
      pulse(on2);
      cyc(4);
      chk_bit(cont === 3'h1, 1'b1, "reverse refused");
      pulse(off);
      chk_cont(3'h0, 3);
      cyc(3);
      pulse(on2);
      cyc(4);
      chk_bit(cont === 3'h0, 1'b1, "lock-out");
      cyc(40);
      pulse(on2);
      chk_cont(3'h2, 3);
      cyc(4);
      chk_bit(l2 & s2, 1'b1, "right lamp");
      lock = 16'h0000;
      pulse(off);
      chk_cont(3'h0, 3);
      cyc(4);
      pulse(on1);
      chk_cont(3'h1, 3);
      pulse(off);
      pulse(on2);
      cyc(4);
      chk_bit(cont === 3'h0, 1'b1, "not yet at rest");
      cyc(8);
      // star delta by time
      func = mss_pkg::MSS_FN_STAR_DELTA;
      cyc(2);
      pulse(on2);
      chk_cont(3'h3, 3);
      k = 0;
      while (cont.b === 1'b1 && k < 400) begin
         cyc(1);
         k++;
      end
      chk_bit(k >= 95 && k <= 106, 1'b1, "time changeover");
      chk_cont(3'h5, 12);
      cyc(6);
      chk_bit(flt === 4'h0 && l2 === 1'b1, 1'b1, "delta run");
      pulse(off);
      chk_cont(3'h0, 3);
      cyc(12);
      // star delta by falling current
      by_cur = 1'b1;
      cls = 16'h01F4;
      pulse(on2);
      chk_cont(3'h3, 3);
      k = 0;
      while (cont.b === 1'b1 && k < 400) begin
         cyc(1);
         k++;
      end
      chk_bit(mcur <= 16'h005A && mcur >= 16'h0054, 1'b1, "current");
      chk_cont(3'h5, 12);
      pulse(off);
      chk_cont(3'h0, 3);
      cyc(4);
      summarize();
   end
endmodule
